// file: inc/ajs_pkg.sv
package ajs_pkg;
	// Speed word width, pulses per second
	localparam int SPD_W = 16;
	// Time word width, milliseconds
	localparam int TIME_W = 16;
	// Code register width
	localparam int CODE_W = 16;
	// Clock rate and one millisecond tick
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	// Operation state codes
	localparam logic [7:0] OPST_IDLE = 8'h00;
	localparam logic [7:0] OPST_JOG = 8'h02;
	localparam logic [7:0] OPST_POS = 8'h01;
	localparam logic [7:0] OPST_SPEED = 8'h0A;
	// Error and warning codes (decimal values)
	localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
	localparam logic [CODE_W-1:0] WARN_SPEED_RANGE = 16'd1020;
	localparam logic [CODE_W-1:0] ERR_STOP_AT_START = 16'd1102;
	// Motion modes
	localparam logic [1:0] MODE_POS = 2'h0;
	localparam logic [1:0] MODE_SPEED = 2'h1;
	// Feed value width
	localparam int FEED_W = 32;
	localparam logic [FEED_W-1:0] FEED_ZERO = 32'h0000_0000;
	localparam logic [SPD_W-1:0] SPD_ZERO = 16'h0000;
	localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
endpackage : ajs_pkg

// file: verification/ajs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on axis 0 and on the joint start
module ajs_checker
	import ajs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Commands
	input wire logic [1:0] jog_start_cmd,
	input wire logic [1:0] axis_stop_cmd,
	input wire logic [1:0] error_reset,
	input wire logic dual_axis_start_cmd,
	input wire logic [1:0] data_valid,
	// Status
	input wire logic [1:0] axis_busy_flag,
	input wire logic [1:0] positioning_done_flag,
	input wire logic [1:0] zero_speed_flag,
	input wire logic [7:0] axis_operation_state_0,
	input wire logic [ajs_pkg::FEED_W-1:0] current_feed_value_0,
	input wire logic [ajs_pkg::CODE_W-1:0] axis_code_0,
	input wire logic [1:0] pulse_out,
	input wire logic [1:0] move_dir
);
	// One domain, so one clock and one disable for all
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Stop held before the JOG edge, then held while it syncs
	sequence stop_then_jog0;
		axis_stop_cmd[0][*3] ##1 ($rose(jog_start_cmd[0]) && axis_stop_cmd[0]
			&& !error_reset[0] && !axis_busy_flag[0]) ##1 axis_stop_cmd[0][*2];
	endsequence
	// Joint start edge with both axes quiet
	sequence dual_idle_rise;
		$rose(dual_axis_start_cmd) && axis_busy_flag == 2'b00 && axis_stop_cmd == 2'b00
			&& jog_start_cmd == 2'b00;
	endsequence
	spd_no_done_a: assert property (axis_operation_state_0 == OPST_SPEED |->
		!positioning_done_flag[0] && current_feed_value_0 == FEED_ZERO)
		else $error("done flag or feed value moved in speed control");
	spd_stall_a: assert property (zero_speed_flag[0] && $past(zero_speed_flag[0])
		&& axis_operation_state_0 == OPST_SPEED |-> axis_busy_flag[0] && !pulse_out[0])
		else $error("speed control stall not held");
	jog_stall_a: assert property (zero_speed_flag[0] && $past(zero_speed_flag[0])
		&& axis_operation_state_0 == OPST_JOG |-> axis_busy_flag[0] && !pulse_out[0])
		else $error("jog stall not held");
	jog_start_a: assert property ($rose(jog_start_cmd[0]) && !axis_stop_cmd[0]
		&& !axis_busy_flag[0] |-> ##3 axis_busy_flag[0] && axis_operation_state_0 == OPST_JOG)
		else $error("jog start did not raise busy");
	stop_err_a: assert property (stop_then_jog0 |->
		##1 axis_code_0 == ERR_STOP_AT_START && !axis_busy_flag[0])
		else $error("jog start with stop held not refused");
	dir_steady_a: assert property (axis_busy_flag[0][*3] |-> $stable(move_dir[0]))
		else $error("direction changed while busy");
	idle_quiet_a: assert property (!axis_busy_flag[0][*2] |-> !pulse_out[0])
		else $error("pulse while idle");
	busy_cause_a: assert property ($rose(axis_busy_flag[0]) |->
		$past(jog_start_cmd[0], 3) || $past(dual_axis_start_cmd, 4))
		else $error("busy rose without a start");
	code_clear_a: assert property (axis_code_0 != CODE_NONE ##1 axis_code_0 == CODE_NONE
		|-> $past(error_reset[0], 3))
		else $error("code cleared without error reset");
	dual_start_a: assert property ((dual_idle_rise and data_valid != 2'b00) |->
		##4 axis_busy_flag == data_valid)
		else $error("joint start did not start the valid axes");
	dual_busy_a: assert property ($rose(dual_axis_start_cmd) && axis_busy_flag == 2'b01
		&& !jog_start_cmd[1] |-> ##4 axis_busy_flag == 2'b01)
		else $error("joint start acted while an axis moved");
endmodule : ajs_checker
bind ajs_top ajs_checker ajs_checker_i (.*);
`default_nettype wire

// file: verification/ajs_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// Motor drive: counts command pulses per axis
module ajs_drive_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Pulse train and direction
	input wire logic [1:0] pulse_out,
	input wire logic [1:0] move_dir,
	// Position seen by the drive
	output logic signed [31:0] pos_0,
	output logic signed [31:0] pos_1
);
	logic signed [31:0] pos_0_next;
	logic signed [31:0] pos_1_next;
	// One step per pulse, reverse counts down
	always_comb begin
		pos_0_next = pos_0;
		pos_1_next = pos_1;
		if (pulse_out[0]) begin
			pos_0_next = move_dir[0] ? pos_0 - 32'sh0000_0001 : pos_0 + 32'sh0000_0001;
		end
		if (pulse_out[1]) begin
			pos_1_next = move_dir[1] ? pos_1 - 32'sh0000_0001 : pos_1 + 32'sh0000_0001;
		end
	end
	// Position registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pos_0 <= 32'sh0000_0000;
			pos_1 <= 32'sh0000_0000;
		end else begin
			pos_0 <= pos_0_next;
			pos_1 <= pos_1_next;
		end
	end
endmodule : ajs_drive_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the two-axis JOG and speed sequencer
module tb_top;
	import ajs_pkg::*;
	// Clock, reset, scoreboard
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	int fail_count = 0;
	int checks = 0;
	logic signed [31:0] base_0, base_1;
	// Commands and data, ramps instant
	logic [1:0] jog_start_cmd = 2'h0, jog_dir = 2'h0, axis_stop_cmd = 2'h0, pos_dir = 2'h0;
	logic [1:0] speed_change_cmd = 2'h0, error_reset = 2'h0, data_valid = 2'h0;
	logic [1:0] pos_mode_0 = MODE_POS, pos_mode_1 = MODE_POS;
	logic dual_axis_start_cmd = 1'b0;
	logic [SPD_W-1:0] new_speed_0 = 16'h0000, new_speed_1 = 16'h0000, bias_speed = 16'h0000;
	logic [SPD_W-1:0] jog_speed_0 = 16'hC350, jog_speed_1 = 16'hC350, speed_limit = 16'hEA60;
	logic [SPD_W-1:0] cmd_speed_0 = 16'hC350, cmd_speed_1 = 16'hC350;
	logic [TIME_W-1:0] jog_acc_ms = 16'h0000, jog_dec_ms = 16'h0000;
	logic [FEED_W-1:0] move_amount_0 = 32'h0000_0003, move_amount_1 = 32'h0000_0006;
	// Outputs and drive position
	logic [1:0] axis_busy_flag, positioning_done_flag, zero_speed_flag, pulse_out, move_dir;
	logic [7:0] axis_operation_state_0, axis_operation_state_1;
	logic [FEED_W-1:0] current_feed_value_0, current_feed_value_1;
	logic [CODE_W-1:0] axis_code_0, axis_code_1;
	logic signed [31:0] pos_0, pos_1;
	ajs_top ajs_top_i (.*);
	ajs_drive_model ajs_drive_model_i (.*);
	// 100 MHz clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	// Let edges pass, then sample settled outputs
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	// Bounded wait for a busy level
	task automatic wait_busy(input int ax, input logic v, input int lim);
		int n;
		n = 0;
		#1;
		while (axis_busy_flag[ax] !== v && n < lim) begin
			cyc(1);
			n++;
		end
		chk("busy", 32'(v), 32'(axis_busy_flag[ax]));
	endtask : wait_busy
	// Axis 0 command drivers
	task automatic jog0(input logic v);
		@(posedge clk_sys);
		jog_start_cmd[0] <= v;
	endtask : jog0
	task automatic stop0(input logic v);
		@(posedge clk_sys);
		axis_stop_cmd[0] <= v;
	endtask : stop0
	task automatic spd0(input logic [SPD_W-1:0] v);
		@(posedge clk_sys);
		new_speed_0 <= v;
		speed_change_cmd[0] <= 1'b1;
		@(posedge clk_sys);
		speed_change_cmd[0] <= 1'b0;
		cyc(6);
	endtask : spd0
	task automatic errclr0();
		@(posedge clk_sys);
		error_reset[0] <= 1'b1;
		@(posedge clk_sys);
		error_reset[0] <= 1'b0;
		cyc(5);
		chk("code0", CODE_NONE, axis_code_0);
	endtask : errclr0
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	// Watchdog well past the expected run
	initial begin
		repeat (80000) @(posedge clk_sys);
		fail_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(4);
		// Forward JOG, hold, release
		jog0(1'b1);
		wait_busy(0, 1'b1, 8);
		chk("state0", OPST_JOG, axis_operation_state_0);
		base_0 = pos_0;
		cyc(10000);
		chk("jog run", 1, (pos_0 - base_0) inside {[4:6]});
		jog0(1'b0);
		wait_busy(0, 1'b0, 50);
		chk("state0", OPST_IDLE, axis_operation_state_0);
		base_0 = pos_0;
		cyc(4000);
		chk("halted", base_0, pos_0);
		// Reverse once idle, then a stop pulse while held
		@(posedge clk_sys);
		jog_dir[0] <= 1'b1;
		jog0(1'b1);
		wait_busy(0, 1'b1, 8);
		cyc(4000);
		chk("dir0", 1, move_dir[0]);
		chk("reverse", 1, pos_0 < base_0);
		stop0(1'b1);
		cyc(4);
		stop0(1'b0);
		wait_busy(0, 1'b0, 50);
		cyc(50);
		chk("no restart", 0, axis_busy_flag[0]);
		jog0(1'b0);
		cyc(5);
		jog0(1'b1);
		wait_busy(0, 1'b1, 8);
		jog0(1'b0);
		wait_busy(0, 1'b0, 50);
		// Start refused with stop held, then recovery
		stop0(1'b1);
		jog_dir[0] <= 1'b0;
		cyc(5);
		jog0(1'b1);
		cyc(6);
		chk("code0", ERR_STOP_AT_START, axis_code_0);
		chk("busy0", 0, axis_busy_flag[0]);
		jog0(1'b0);
		errclr0();
		stop0(1'b0);
		cyc(5);
		jog0(1'b1);
		wait_busy(0, 1'b1, 8);
		// Release for one cycle: the new edge lands in deceleration
		jog0(1'b0);
		jog0(1'b1);
		wait_busy(0, 1'b0, 50);
		cyc(50);
		chk("no resume", 0, axis_busy_flag[0]);
		jog0(1'b0);
		// Clamp to the limit, then to the bias speed
		@(posedge clk_sys);
		jog_speed_0 <= 16'hFDE8;
		jog0(1'b1);
		cyc(6);
		chk("code0", WARN_SPEED_RANGE, axis_code_0);
		jog0(1'b0);
		errclr0();
		@(posedge clk_sys);
		jog_speed_0 <= 16'h01F4;
		bias_speed <= 16'h03E8;
		jog0(1'b1);
		cyc(6);
		chk("code0", WARN_SPEED_RANGE, axis_code_0);
		errclr0();
		spd0(16'h0000);
		chk("code0", WARN_SPEED_RANGE, axis_code_0);
		chk("busy0", 1, axis_busy_flag[0]);
		chk("zero0", 0, zero_speed_flag[0]);
		jog0(1'b0);
		wait_busy(0, 1'b0, 50);
		errclr0();
		// Zero JOG speed stalls, a speed change resumes
		@(posedge clk_sys);
		bias_speed <= 16'h0000;
		jog_speed_0 <= 16'h0000;
		jog0(1'b1);
		cyc(6);
		chk("zero0", 1, zero_speed_flag[0]);
		chk("state0", OPST_JOG, axis_operation_state_0);
		chk("busy0", 1, axis_busy_flag[0]);
		base_0 = pos_0;
		cyc(3000);
		chk("stall", base_0, pos_0);
		spd0(16'hC350);
		chk("zero0", 0, zero_speed_flag[0]);
		cyc(4000);
		chk("resume", 1, pos_0 != base_0);
		jog0(1'b0);
		wait_busy(0, 1'b0, 50);
		// Joint start into speed control, axis 1 data bad
		@(posedge clk_sys);
		pos_mode_0 <= MODE_SPEED;
		cmd_speed_0 <= 16'h0000;
		data_valid <= 2'b01;
		@(posedge clk_sys);
		dual_axis_start_cmd <= 1'b1;
		cyc(6);
		chk("busy", 2'b01, axis_busy_flag);
		chk("state0", OPST_SPEED, axis_operation_state_0);
		chk("zero0", 1, zero_speed_flag[0]);
		spd0(16'hC350);
		chk("zero0", 0, zero_speed_flag[0]);
		base_0 = pos_0;
		cyc(5000);
		chk("speed run", 1, pos_0 != base_0);
		chk("feed0", FEED_ZERO, current_feed_value_0);
		chk("done0", 0, positioning_done_flag[0]);
		@(posedge clk_sys);
		dual_axis_start_cmd <= 1'b0;
		data_valid <= 2'b11;
		cyc(5);
		@(posedge clk_sys);
		dual_axis_start_cmd <= 1'b1;
		cyc(6);
		chk("busy", 2'b01, axis_busy_flag);
		@(posedge clk_sys);
		bias_speed <= 16'h03E8;
		spd0(16'h0000);
		chk("code0", WARN_SPEED_RANGE, axis_code_0);
		chk("busy0", 1, axis_busy_flag[0]);
		stop0(1'b1);
		wait_busy(0, 1'b0, 50);
		stop0(1'b0);
		errclr0();
		// Joint positioning, each axis ends on its own
		@(posedge clk_sys);
		dual_axis_start_cmd <= 1'b0;
		pos_mode_0 <= MODE_POS;
		cmd_speed_0 <= 16'hC350;
		pos_dir <= 2'b10;
		cyc(5);
		base_0 = pos_0;
		base_1 = pos_1;
		@(posedge clk_sys);
		dual_axis_start_cmd <= 1'b1;
		cyc(6);
		chk("busy", 2'b11, axis_busy_flag);
		wait_busy(0, 1'b0, 20000);
		chk("busy1", 1, axis_busy_flag[1]);
		chk("pos0", 3, pos_0 - base_0);
		wait_busy(1, 1'b0, 20000);
		chk("pos1", 32'hFFFF_FFFA, pos_1 - base_1);
		chk("done", 2'b11, positioning_done_flag);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire

// file: verilog/ajs_axis.sv
`timescale 1ns/1ps
`default_nettype none
// One axis: JOG, speed control, positioning profile with ramps
module ajs_axis (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick,
	// Commands, synchronised except new_speed and sim_ok
	input wire logic jog_start_cmd,
	input wire logic jog_dir,
	input wire logic axis_stop_cmd,
	input wire logic speed_change_cmd,
	input wire logic [ajs_pkg::SPD_W-1:0] new_speed,
	input wire logic error_reset,
	input wire logic sim_go,
	input wire logic sim_ok,
	// JOG parameter block
	input wire logic [ajs_pkg::SPD_W-1:0] jog_speed,
	input wire logic [ajs_pkg::TIME_W-1:0] jog_acc_ms,
	input wire logic [ajs_pkg::TIME_W-1:0] jog_dec_ms,
	// Positioning data
	input wire logic [1:0] pos_mode,
	input wire logic [ajs_pkg::SPD_W-1:0] cmd_speed,
	input wire logic [ajs_pkg::FEED_W-1:0] move_amount,
	input wire logic pos_dir,
	// Axis limits
	input wire logic [ajs_pkg::SPD_W-1:0] bias_speed,
	input wire logic [ajs_pkg::SPD_W-1:0] speed_limit,
	// Status
	output logic axis_busy_flag,
	output logic positioning_done_flag,
	output logic zero_speed_flag,
	output logic [7:0] axis_operation_state,
	output logic [ajs_pkg::FEED_W-1:0] current_feed_value,
	output logic [ajs_pkg::CODE_W-1:0] axis_code,
	output logic [ajs_pkg::SPD_W-1:0] cur_speed,
	output logic move_dir,
	output logic pulse_out
);
	import ajs_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ACC = 3'b001,
		ST_RUN = 3'b010,
		ST_DEC = 3'b011,
		ST_ZERO = 3'b100
	} ajs_state_t;

	ajs_state_t state_reg, state_next;
	logic jog_reg, jog_next;                 // Motion started by JOG
	logic spdctl_reg, spdctl_next;           // Speed control mode
	logic jog_prev_reg, jog_prev_next;       // Previous JOG command level
	logic [SPD_W-1:0] spd_reg, spd_next;     // Present speed
	logic [SPD_W-1:0] tgt_reg, tgt_next;     // Target speed
	logic [SPD_W-1:0] step_reg, step_next;   // Ramp step per tick
	logic [TIME_W-1:0] dec_reg, dec_next;    // Deceleration time
	logic dir_reg, dir_next;
	logic done_reg, done_next;
	logic zero_reg, zero_next;
	logic [7:0] opst_reg, opst_next;
	logic [FEED_W-1:0] feed_reg, feed_next;
	logic [FEED_W-1:0] left_reg, left_next;  // Remaining movement
	logic [CODE_W-1:0] code_reg, code_next;
	logic [31:0] acc_reg, acc_next;          // Pulse phase accumulator
	logic pulse_reg, pulse_next;
	logic busy_reg, busy_next;               // Busy, registered for the port
	logic jog_rise;
	logic [SPD_W-1:0] clamp_spd;
	logic clamp_warn;
	logic [SPD_W-1:0] pick_spd;
	logic [32:0] acc_sum;

	// Step for a ramp from zero to a speed over a time in ms
	function automatic logic [SPD_W-1:0] ramp_step(input logic [SPD_W-1:0] spd,
			input logic [TIME_W-1:0] ms);
		logic [SPD_W-1:0] s;
		s = (ms == TIME_ZERO) ? spd : SPD_W'(spd / ms);
		ramp_step = (s == SPD_ZERO) ? 16'h0001 : s;
	endfunction : ramp_step

	assign jog_rise = jog_start_cmd && !jog_prev_reg;

	// Choose a requested speed source
	always_comb begin
		if (state_reg == ST_IDLE) begin
			pick_spd = jog_rise ? jog_speed : cmd_speed;
		end else begin
			pick_spd = new_speed;
		end
	end

	// Clamp a speed to bias and limit; zero with zero bias stays zero
	always_comb begin
		clamp_spd = pick_spd;
		clamp_warn = 1'b0;
		if (pick_spd > speed_limit) begin
			clamp_spd = speed_limit;
			clamp_warn = 1'b1;
		end else if (pick_spd < bias_speed) begin
			clamp_spd = bias_speed;
			clamp_warn = 1'b1;
		end
	end

	// Next state of the axis sequencer
	always_comb begin
		state_next = state_reg;
		jog_next = jog_reg;
		spdctl_next = spdctl_reg;
		jog_prev_next = jog_start_cmd;
		spd_next = spd_reg;
		tgt_next = tgt_reg;
		step_next = step_reg;
		dec_next = dec_reg;
		dir_next = dir_reg;
		done_next = done_reg;
		zero_next = zero_reg;
		opst_next = opst_reg;
		feed_next = feed_reg;
		left_next = left_reg;
		code_next = code_reg;
		if (error_reset) begin
			code_next = CODE_NONE;
		end
		unique case (state_reg)
			ST_IDLE: begin
				// Start requests are only looked at while not busy
				if (jog_rise && axis_stop_cmd) begin
					code_next = ERR_STOP_AT_START;
				end else if (jog_rise) begin
					jog_next = 1'b1;
					spdctl_next = 1'b0;
					dir_next = jog_dir;
					tgt_next = clamp_spd;
					step_next = ramp_step(clamp_spd, jog_acc_ms);
					dec_next = jog_dec_ms;
					done_next = 1'b0;
					opst_next = OPST_JOG;
					if (clamp_warn) begin
						code_next = WARN_SPEED_RANGE;
					end
					if (clamp_spd == SPD_ZERO) begin
						zero_next = 1'b1;
						state_next = ST_ZERO;
					end else begin
						state_next = ST_ACC;
					end
				end else if (sim_go && sim_ok && !axis_stop_cmd) begin
					jog_next = 1'b0;
					spdctl_next = (pos_mode == MODE_SPEED);
					dir_next = pos_dir;
					tgt_next = clamp_spd;
					step_next = ramp_step(clamp_spd, jog_acc_ms);
					dec_next = jog_dec_ms;
					done_next = 1'b0;
					left_next = move_amount;
					opst_next = (pos_mode == MODE_SPEED) ? OPST_SPEED : OPST_POS;
					if (pos_mode == MODE_SPEED) begin
						feed_next = FEED_ZERO;
					end
					if (clamp_warn) begin
						code_next = WARN_SPEED_RANGE;
					end
					if (clamp_spd == SPD_ZERO) begin
						zero_next = 1'b1;
						state_next = ST_ZERO;
					end else begin
						state_next = ST_ACC;
					end
				end
			end
			ST_ZERO: begin
				// Stalled at zero speed, busy held
				if (axis_stop_cmd || (jog_reg && !jog_start_cmd)) begin
					zero_next = 1'b0;
					state_next = ST_IDLE;
					opst_next = OPST_IDLE;
				end else if (speed_change_cmd && clamp_spd != SPD_ZERO) begin
					zero_next = 1'b0;
					tgt_next = clamp_spd;
					step_next = ramp_step(clamp_spd, jog_acc_ms);
					state_next = ST_ACC;
					if (clamp_warn) begin
						code_next = WARN_SPEED_RANGE;
					end
				end
			end
			ST_ACC, ST_RUN: begin
				if (axis_stop_cmd || (jog_reg && !jog_start_cmd)) begin
					step_next = ramp_step(spd_reg, dec_reg);
					state_next = ST_DEC;
				end else begin
					if (speed_change_cmd) begin
						if (clamp_spd == SPD_ZERO) begin
							zero_next = 1'b1;
							spd_next = SPD_ZERO;
							state_next = ST_ZERO;
						end else begin
							tgt_next = clamp_spd;
							state_next = ST_ACC;
						end
						if (clamp_warn) begin
							code_next = WARN_SPEED_RANGE;
						end
					end else if ((tick || jog_acc_ms == TIME_ZERO) && spd_reg != tgt_reg) begin
						// Zero ramp time steps at once instead of waiting a tick
						// Ramp toward target in either direction
						if (spd_reg < tgt_reg) begin
							spd_next = (tgt_reg - spd_reg > step_reg) ? SPD_W'(spd_reg + step_reg)
								: tgt_reg;
						end else begin
							spd_next = (spd_reg - tgt_reg > step_reg) ? SPD_W'(spd_reg - step_reg)
								: tgt_reg;
						end
					end else if (spd_reg == tgt_reg) begin
						state_next = ST_RUN;
					end
				end
			end
			ST_DEC: begin
				// Speed change requests are dropped here; zero time stops at once
				if (tick || dec_reg == TIME_ZERO) begin
					if (spd_reg > step_reg) begin
						spd_next = SPD_W'(spd_reg - step_reg);
					end else begin
						spd_next = SPD_ZERO;
					end
				end
				if (spd_reg == SPD_ZERO) begin
					state_next = ST_IDLE;
					opst_next = OPST_IDLE;
					jog_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Pulse counting: feed value and positioning end
		if (pulse_reg && !spdctl_reg) begin
			feed_next = dir_reg ? FEED_W'(feed_reg - 1) : FEED_W'(feed_reg + 1);
			if (!jog_reg && left_reg != FEED_ZERO) begin
				left_next = FEED_W'(left_reg - 1);
				if (left_reg == 32'h0000_0001) begin
					spd_next = SPD_ZERO;
					state_next = ST_IDLE;
					opst_next = OPST_IDLE;
					done_next = 1'b1;
				end
			end
		end
		if (spdctl_reg) begin
			feed_next = FEED_ZERO;
			done_next = 1'b0;
		end
		// Busy follows the next state so the port comes from a flop
		busy_next = (state_next != ST_IDLE);
	end

	// Pulse generator: phase accumulator at speed pulses per second
	always_comb begin
		acc_sum = {1'b0, acc_reg} + 33'(spd_reg);
		acc_next = acc_reg;
		pulse_next = 1'b0;
		if (state_reg == ST_IDLE || state_reg == ST_ZERO) begin
			acc_next = 32'h0000_0000;
		end else if (acc_sum >= 33'(CLK_HZ)) begin
			acc_next = 32'(acc_sum - 33'(CLK_HZ));
			pulse_next = 1'b1;
		end else begin
			acc_next = acc_sum[31:0];
		end
	end

	// Register all state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			jog_reg <= 1'b0;
			spdctl_reg <= 1'b0;
			jog_prev_reg <= 1'b0;
			spd_reg <= SPD_ZERO;
			tgt_reg <= SPD_ZERO;
			step_reg <= SPD_ZERO;
			dec_reg <= TIME_ZERO;
			dir_reg <= 1'b0;
			done_reg <= 1'b0;
			zero_reg <= 1'b0;
			opst_reg <= OPST_IDLE;
			feed_reg <= FEED_ZERO;
			left_reg <= FEED_ZERO;
			code_reg <= CODE_NONE;
			acc_reg <= 32'h0000_0000;
			pulse_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			jog_reg <= jog_next;
			spdctl_reg <= spdctl_next;
			jog_prev_reg <= jog_prev_next;
			spd_reg <= spd_next;
			tgt_reg <= tgt_next;
			step_reg <= step_next;
			dec_reg <= dec_next;
			dir_reg <= dir_next;
			done_reg <= done_next;
			zero_reg <= zero_next;
			opst_reg <= opst_next;
			feed_reg <= feed_next;
			left_reg <= left_next;
			code_reg <= code_next;
			acc_reg <= acc_next;
			pulse_reg <= pulse_next;
			busy_reg <= busy_next;
		end
	end

	// Outputs straight from flip-flops
	assign axis_busy_flag = busy_reg;
	assign positioning_done_flag = done_reg;
	assign zero_speed_flag = zero_reg;
	assign axis_operation_state = opst_reg;
	assign current_feed_value = feed_reg;
	assign axis_code = code_reg;
	assign cur_speed = spd_reg;
	assign move_dir = dir_reg;
	assign pulse_out = pulse_reg;
endmodule : ajs_axis
`default_nettype wire

// file: verilog/ajs_top.sv
`timescale 1ns/1ps
`default_nettype none
module ajs_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Controller commands, per axis [0]/[1], plus the joint start
	input wire logic [1:0] jog_start_cmd,
	input wire logic [1:0] jog_dir,
	input wire logic [1:0] axis_stop_cmd,
	input wire logic [1:0] speed_change_cmd,
	input wire logic [1:0] error_reset,
	input wire logic dual_axis_start_cmd,
	// Speed change values
	input wire logic [ajs_pkg::SPD_W-1:0] new_speed_0,
	input wire logic [ajs_pkg::SPD_W-1:0] new_speed_1,
	// JOG parameter blocks
	input wire logic [ajs_pkg::SPD_W-1:0] jog_speed_0,
	input wire logic [ajs_pkg::SPD_W-1:0] jog_speed_1,
	input wire logic [ajs_pkg::TIME_W-1:0] jog_acc_ms,
	input wire logic [ajs_pkg::TIME_W-1:0] jog_dec_ms,
	// Positioning data
	input wire logic [1:0] pos_mode_0,
	input wire logic [1:0] pos_mode_1,
	input wire logic [ajs_pkg::SPD_W-1:0] cmd_speed_0,
	input wire logic [ajs_pkg::SPD_W-1:0] cmd_speed_1,
	input wire logic [ajs_pkg::FEED_W-1:0] move_amount_0,
	input wire logic [ajs_pkg::FEED_W-1:0] move_amount_1,
	input wire logic [1:0] pos_dir,
	input wire logic [1:0] data_valid,
	// Limits
	input wire logic [ajs_pkg::SPD_W-1:0] bias_speed,
	input wire logic [ajs_pkg::SPD_W-1:0] speed_limit,
	// Status per axis
	output logic [1:0] axis_busy_flag,
	output logic [1:0] positioning_done_flag,
	output logic [1:0] zero_speed_flag,
	output logic [7:0] axis_operation_state_0,
	output logic [7:0] axis_operation_state_1,
	output logic [ajs_pkg::FEED_W-1:0] current_feed_value_0,
	output logic [ajs_pkg::FEED_W-1:0] current_feed_value_1,
	output logic [ajs_pkg::CODE_W-1:0] axis_code_0,
	output logic [ajs_pkg::CODE_W-1:0] axis_code_1,
	// Drive pulse outputs
	output logic [1:0] pulse_out,
	output logic [1:0] move_dir
);
	import ajs_pkg::*;

	// Commands come from a slower program domain; two-stage sync
	logic [10:0] cmd_s1_reg, cmd_s2_reg;
	logic [10:0] cmd_raw;
	logic [1:0] jog_s, dir_s, stop_s, chg_s, rst_s;
	logic sim_s, sim_prev_reg, sim_rise;
	logic sim_go_reg, sim_go_next;
	logic [1:0] sim_ok_reg, sim_ok_next;
	logic [16:0] tick_cnt_reg, tick_cnt_next; // One millisecond needs 17 bits
	logic tick_reg, tick_next;
	logic [1:0] busy_w;

	assign cmd_raw = {dual_axis_start_cmd, error_reset, speed_change_cmd, axis_stop_cmd,
		jog_dir, jog_start_cmd};

	// Synchroniser stages
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_s1_reg <= 11'h000;
			cmd_s2_reg <= 11'h000;
			sim_prev_reg <= 1'b0;
		end else begin
			cmd_s1_reg <= cmd_raw;
			cmd_s2_reg <= cmd_s1_reg;
			sim_prev_reg <= sim_s;
		end
	end

	assign jog_s = cmd_s2_reg[1:0];
	assign dir_s = cmd_s2_reg[3:2];
	assign stop_s = cmd_s2_reg[5:4];
	assign chg_s = cmd_s2_reg[7:6];
	assign rst_s = cmd_s2_reg[9:8];
	assign sim_s = cmd_s2_reg[10];
	assign sim_rise = sim_s && !sim_prev_reg;

	// Joint start decision and ramp tick
	always_comb begin
		sim_go_next = 1'b0;
		sim_ok_next = 2'b00;
		if (sim_rise && busy_w == 2'b00) begin
			sim_go_next = 1'b1;
			sim_ok_next = data_valid;
		end
		if (tick_cnt_reg == 17'(TICK_CYC - 1)) begin
			tick_cnt_next = 17'h0_0000;
			tick_next = 1'b1;
		end else begin
			tick_cnt_next = 17'(tick_cnt_reg + 17'h0_0001);
			tick_next = 1'b0;
		end
	end

	// Register joint start and tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sim_go_reg <= 1'b0;
			sim_ok_reg <= 2'b00;
			tick_cnt_reg <= 17'h0_0000;
			tick_reg <= 1'b0;
		end else begin
			sim_go_reg <= sim_go_next;
			sim_ok_reg <= sim_ok_next;
			tick_cnt_reg <= tick_cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign axis_busy_flag = busy_w;

	// Axis 0; each axis takes only its own stop input
	ajs_axis u_axis0 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick(tick_reg),
		.jog_start_cmd(jog_s[0]),
		.jog_dir(dir_s[0]),
		.axis_stop_cmd(stop_s[0]),
		.speed_change_cmd(chg_s[0]),
		.new_speed(new_speed_0),
		.error_reset(rst_s[0]),
		.sim_go(sim_go_reg),
		.sim_ok(sim_ok_reg[0]),
		.jog_speed(jog_speed_0),
		.jog_acc_ms(jog_acc_ms),
		.jog_dec_ms(jog_dec_ms),
		.pos_mode(pos_mode_0),
		.cmd_speed(cmd_speed_0),
		.move_amount(move_amount_0),
		.pos_dir(pos_dir[0]),
		.bias_speed(bias_speed),
		.speed_limit(speed_limit),
		.axis_busy_flag(busy_w[0]),
		.positioning_done_flag(positioning_done_flag[0]),
		.zero_speed_flag(zero_speed_flag[0]),
		.axis_operation_state(axis_operation_state_0),
		.current_feed_value(current_feed_value_0),
		.axis_code(axis_code_0),
		.cur_speed(),
		.move_dir(move_dir[0]),
		.pulse_out(pulse_out[0])
	);

	// Axis 1
	ajs_axis u_axis1 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick(tick_reg),
		.jog_start_cmd(jog_s[1]),
		.jog_dir(dir_s[1]),
		.axis_stop_cmd(stop_s[1]),
		.speed_change_cmd(chg_s[1]),
		.new_speed(new_speed_1),
		.error_reset(rst_s[1]),
		.sim_go(sim_go_reg),
		.sim_ok(sim_ok_reg[1]),
		.jog_speed(jog_speed_1),
		.jog_acc_ms(jog_acc_ms),
		.jog_dec_ms(jog_dec_ms),
		.pos_mode(pos_mode_1),
		.cmd_speed(cmd_speed_1),
		.move_amount(move_amount_1),
		.pos_dir(pos_dir[1]),
		.bias_speed(bias_speed),
		.speed_limit(speed_limit),
		.axis_busy_flag(busy_w[1]),
		.positioning_done_flag(positioning_done_flag[1]),
		.zero_speed_flag(zero_speed_flag[1]),
		.axis_operation_state(axis_operation_state_1),
		.current_feed_value(current_feed_value_1),
		.axis_code(axis_code_1),
		.cur_speed(),
		.move_dir(move_dir[1]),
		.pulse_out(pulse_out[1])
	);
endmodule : ajs_top
`default_nettype wire
